// file: hw/pld_pkg.sv
// Package of register indices, field positions and reset values for the link drop and MAC port config block.
// Assumes a 32-bit APB master with word-aligned byte addresses equal to four times each register index.
package pld_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned ENERGY_W = 8;
    localparam int unsigned NCAUSE = 5;

    // Register indices as numbered in the device map; byte address is four times the index.
    localparam logic [7:0] IDX_LINK_DROP_CONFIG = 8'h2D;
    localparam logic [7:0] IDX_LINK_DROP_THRESHOLD_CONFIG = 8'h2E;
    localparam logic [7:0] IDX_MISC_CONFIG_FOUR = 8'h31;
    localparam logic [7:0] IDX_MAC_PORT_CONTROL = 8'h32;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h3C;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h3D;

    localparam logic [ADDR_W-1:0] ADDR_LINK_DROP_CONFIG = {IDX_LINK_DROP_CONFIG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LINK_DROP_THRESHOLD_CONFIG = {IDX_LINK_DROP_THRESHOLD_CONFIG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MISC_CONFIG_FOUR = {IDX_MISC_CONFIG_FOUR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MAC_PORT_CONTROL = {IDX_MAC_PORT_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};

    // Link drop configuration fields.
    localparam int unsigned FORCE_DROP_BIT = 15;
    localparam int unsigned FAST_DROP_ENABLE_BIT = 14;
    localparam int unsigned CAUSE_LSB = 8;
    localparam int unsigned SOURCE_MASK_LSB = 0;

    // Drop criterion positions inside the source mask and the cause field.
    localparam int unsigned CAUSE_DESCRAMBLER = 4;
    localparam int unsigned CAUSE_RX_ERROR = 3;
    localparam int unsigned CAUSE_MLT3_ERROR = 2;
    localparam int unsigned CAUSE_SNR = 1;
    localparam int unsigned CAUSE_ENERGY = 0;

    // Threshold configuration fields.
    localparam int unsigned THR_HI_LSB = 8;
    localparam int unsigned THR_MID_LSB = 4;
    localparam int unsigned THR_LSB = 0;

    // Misc configuration four fields.
    localparam int unsigned TEST_MODE_BIT = 7;
    localparam int unsigned MISC_CONFIG_FOUR_SPARE_BIT = 8;
    localparam int unsigned MISC_CONFIG_FOUR_FIXED_LSB = 1;
    localparam int unsigned PORT_MIRROR_BIT = 0;

    // MAC port control fields.
    localparam int unsigned MAC_EN_BIT = 7;
    localparam int unsigned RX_LEVEL_LSB = 5;
    localparam int unsigned TX_LEVEL_LSB = 3;
    localparam int unsigned TX_CLK_SHIFT_BIT = 1;
    localparam int unsigned RX_CLK_SHIFT_BIT = 0;

    // Values after reset.
    localparam logic [2:0] THR_RST = 3'h1;
    localparam logic [2:0] THR_RST_STRAPPED = 3'h2;
    localparam logic [2:0] THR_SPARE_RST = 3'h2;
    localparam logic [5:0] MISC_CONFIG_FOUR_FIXED_VAL = 6'h08;
    localparam logic [1:0] RX_LEVEL_RST = 2'h2;
    localparam logic [1:0] TX_LEVEL_RST = 2'h2;
    localparam logic MAC_EN_RST_FIXED = 1'b1;
    localparam logic [NCAUSE-1:0] MASK_RST = 5'h00;

endpackage

// file: hw/pld_sticky.sv
// Bank of sticky flags: a set holds the bit until a clear, and a set in the same cycle wins.
// Assumes set and clear come from logic on the same clock.
module pld_sticky
    import pld_pkg::*;
#(
    parameter int unsigned W = 1
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] flag_out
);

    logic [W-1:0] flag_reg;

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            flag_reg <= '0;
        end
        else
        begin
            flag_reg <= set_in | (flag_reg & ~clr_in);
        end
    end

    assign flag_out = flag_reg;

endmodule

// file: hw/pld_sync3.sv
// Three-stage synchroniser for pin levels with a two-stage agreement filter.
// Assumes the inputs are slow levels such as straps; the output is defined four edges after power-up.
module pld_sync3
    import pld_pkg::*;
#(
    parameter int unsigned W = 1
)
(
    input wire logic clk_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    // The pipeline carries no reset so that straps are already settled while reset is held.
    always_ff @(posedge clk_in)
    begin
        ff1_reg <= pin_in;
        ff2_reg <= ff1_reg;
        ff3_reg <= ff2_reg;
        level_reg <= level_next;
    end

    always_comb
    begin
        level_next = (ff2_reg & ~(ff2_reg ^ ff3_reg)) | (level_reg & (ff2_reg ^ ff3_reg));
    end

    assign level_out = level_reg;

endmodule

// file: hw/pld_top.sv
// What this block does
// RQ1: Force-drop bit 15 drops the partner link while no signal is received.
// RQ2: Software sets fast-drop enable bit 14 only after link is established.
// RQ3: Source mask bits 4 to 0 enable each drop criterion independently.
// RQ4: An enabled criterion that drops the link latches its cause in bits 12:8.
// RQ5: Latched causes clear on register read unless the condition is still active.
// RQ6: Energy-lost fires when the accumulator falls below the 3-bit threshold, default 0x1.
// RQ7: Strapped fast drop resets the threshold to 0x2; software then writes 0x1.
// RQ8: Software keeps the energy-loss threshold at its recommended value.
// RQ9: Internal test mode bit 7 loads from its strap at reset and stays writable.
// RQ10: Board straps test mode correctly, or software clears the bit.
// RQ11: Port mirroring follows bit 0 of config four, strap default, writable.
// RQ12: Bit 7 enables the MAC port; default 1 or strap, per package option.
// RQ13: Bits 6:5, reset 10, set the receive FIFO half-full level.
// RQ14: Bits 4:3, reset 10, set the transmit FIFO half-full level.
// RQ15: Bit 1 shifts the transmit clock against data; clear keeps it aligned.
// RQ16: Bit 0 shifts the receive clock against data; clear keeps it aligned.
// RQ17: MAC control bits 15:8 and 2 ignore writes and read zero.
// Holds the APB register bank, drop decision logic and interrupt for the link drop and MAC port settings.
// Assumes drop criteria come from detectors on clk_in; strap pins are asynchronous and sampled here.
//
// Local design decision: the APB slave port.
module pld_top
    import pld_pkg::*;
#(
    parameter logic MAC_EN_FROM_STRAP = 1'b1
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic strap_fast_drop_in,
    input wire logic strap_test_mode_in,
    input wire logic strap_mirror_in,
    input wire logic strap_mac_en_in,
    input wire logic signal_detect_in,
    input wire logic descrambler_sync_loss_in,
    input wire logic rx_error_in,
    input wire logic mlt3_error_in,
    input wire logic snr_low_in,
    input wire logic [ENERGY_W-1:0] energy_acc_in,
    output logic link_drop_out,
    output logic energy_lost_out,
    output logic fast_drop_enable_out,
    output logic internal_test_mode_one_out,
    output logic port_mirror_out,
    output logic mac_port_enable_out,
    output logic [1:0] rx_fifo_half_full_level_out,
    output logic [1:0] tx_fifo_half_full_level_out,
    output logic tx_clk_shift_out,
    output logic rx_clk_shift_out,
    output logic irq_out
);

    logic [3:0] strap_level;
    logic strap_fast_drop;
    logic strap_test_mode;
    logic strap_mirror;
    logic strap_mac_en;

    logic force_drop_reg;
    logic fast_drop_enable_reg;
    logic [NCAUSE-1:0] fast_drop_source_mask_reg;
    logic [NCAUSE-1:0] fast_drop_cause_latched;
    logic [2:0] energy_loss_threshold_reg;
    logic [2:0] thr_spare_hi_reg;
    logic [2:0] thr_spare_mid_reg;
    logic internal_test_mode_one_reg;
    logic misc_config_four_spare_reg;
    logic port_mirror_reg;
    logic mac_port_enable_reg;
    logic [1:0] rx_fifo_half_full_level_reg;
    logic [1:0] tx_fifo_half_full_level_reg;
    logic tx_clk_shift_reg;
    logic rx_clk_shift_reg;
    logic [NCAUSE-1:0] irq_mask_reg;
    logic [NCAUSE-1:0] irq_status;
    logic irq_reg;

    logic link_drop_reg;
    logic link_drop_next;
    logic energy_lost_reg;
    logic energy_low;
    logic [NCAUSE-1:0] cause_active;
    logic [NCAUSE-1:0] cause_fire;
    logic [NCAUSE-1:0] cause_fire_prev_reg;
    logic [NCAUSE-1:0] cause_clr;
    logic [NCAUSE-1:0] irq_clr;

    logic [31:0] prdata_reg;
    logic [31:0] rdata_next;
    logic addr_hit;
    logic wr_en;
    logic rd_done;
    logic [15:0] wmask;
    logic [15:0] wdata;

    pld_sync3 #(
        .W(4)
    ) u_strap_sync (
        .clk_in(clk_in),
        .pin_in({strap_fast_drop_in, strap_test_mode_in, strap_mirror_in, strap_mac_en_in}),
        .level_out(strap_level)
    );

    assign strap_fast_drop = strap_level[3];
    assign strap_test_mode = strap_level[2];
    assign strap_mirror = strap_level[1];
    assign strap_mac_en = strap_level[0];

    // Bus decode. Only word-aligned addresses of the six registers answer without error.
    always_comb
    begin
        if (paddr_in == ADDR_LINK_DROP_CONFIG)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr_in == ADDR_LINK_DROP_THRESHOLD_CONFIG)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr_in == ADDR_MISC_CONFIG_FOUR)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr_in == ADDR_MAC_PORT_CONTROL)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr_in == ADDR_IRQ_STATUS)
        begin
            addr_hit = 1'b1;
        end
        else if (paddr_in == ADDR_IRQ_MASK)
        begin
            addr_hit = 1'b1;
        end
        else
        begin
            addr_hit = 1'b0;
        end
    end

    // The slave never inserts wait states, since read data is captured in the setup cycle.
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_hit;
    assign wr_en = psel_in & penable_in & pwrite_in & addr_hit;
    assign rd_done = psel_in & penable_in & ~pwrite_in & addr_hit;
    assign wmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    assign wdata = pwdata_in[15:0];

    // Drop criteria and decision.
    assign energy_low = energy_acc_in < {{(ENERGY_W - 3){1'b0}}, energy_loss_threshold_reg}; // RQ6
    assign cause_active = {descrambler_sync_loss_in, rx_error_in, mlt3_error_in, snr_low_in, energy_low};
    assign cause_fire = cause_active & fast_drop_source_mask_reg & {NCAUSE{fast_drop_enable_reg}}; // RQ3

    always_comb
    begin
        link_drop_next = |cause_fire;
        if (force_drop_reg && !signal_detect_in)
        begin
            link_drop_next = 1'b1; // RQ1
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            link_drop_reg <= 1'b0;
            energy_lost_reg <= 1'b0;
            cause_fire_prev_reg <= '0;
        end
        else
        begin
            link_drop_reg <= link_drop_next;
            energy_lost_reg <= energy_low;
            cause_fire_prev_reg <= cause_fire;
        end
    end

    // A read clears the latched causes, but a cause still firing sets its bit again in the same edge.
    assign cause_clr = {NCAUSE{rd_done && (paddr_in == ADDR_LINK_DROP_CONFIG)}}; // RQ5

    pld_sticky #(
        .W(NCAUSE)
    ) u_cause_latch (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(cause_fire), // RQ4
        .clr_in(cause_clr),
        .flag_out(fast_drop_cause_latched)
    );

    // Each new firing of a criterion is an interrupt event; writing a one clears its status bit.
    assign irq_clr = wdata[NCAUSE-1:0] & {NCAUSE{wr_en && (paddr_in == ADDR_IRQ_STATUS) && pstrb_in[0]}};

    pld_sticky #(
        .W(NCAUSE)
    ) u_irq_status (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(cause_fire & ~cause_fire_prev_reg),
        .clr_in(irq_clr),
        .flag_out(irq_status)
    );

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(irq_status & irq_mask_reg);
        end
    end

    // Link drop configuration. Bit 14 is only stored; bring-up sequencing is left to software.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            force_drop_reg <= 1'b0;
            fast_drop_enable_reg <= 1'b0; // RQ2
            fast_drop_source_mask_reg <= MASK_RST;
        end
        else if (wr_en && (paddr_in == ADDR_LINK_DROP_CONFIG))
        begin
            if (wmask[FORCE_DROP_BIT])
            begin
                force_drop_reg <= wdata[FORCE_DROP_BIT];
            end
            if (wmask[FAST_DROP_ENABLE_BIT])
            begin
                fast_drop_enable_reg <= wdata[FAST_DROP_ENABLE_BIT];
            end
            if (wmask[SOURCE_MASK_LSB])
            begin
                fast_drop_source_mask_reg <= wdata[SOURCE_MASK_LSB +: NCAUSE]; // RQ3
            end
        end
    end

    // Threshold configuration. The strapped default differs and software must rewrite it.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            energy_loss_threshold_reg <= strap_fast_drop ? THR_RST_STRAPPED : THR_RST; // RQ7
            thr_spare_hi_reg <= THR_SPARE_RST;
            thr_spare_mid_reg <= THR_SPARE_RST;
        end
        else if (wr_en && (paddr_in == ADDR_LINK_DROP_THRESHOLD_CONFIG))
        begin
            if (wmask[THR_LSB])
            begin
                energy_loss_threshold_reg <= wdata[THR_LSB +: 3]; // RQ6
                thr_spare_mid_reg <= wdata[THR_MID_LSB +: 3];
            end
            if (wmask[THR_HI_LSB])
            begin
                thr_spare_hi_reg <= wdata[THR_HI_LSB +: 3];
            end
        end
    end

    // Misc configuration four. Strap values are taken while reset is held.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            internal_test_mode_one_reg <= strap_test_mode; // RQ9
            misc_config_four_spare_reg <= 1'b0;
            port_mirror_reg <= strap_mirror; // RQ11
        end
        else if (wr_en && (paddr_in == ADDR_MISC_CONFIG_FOUR))
        begin
            if (wmask[TEST_MODE_BIT])
            begin
                internal_test_mode_one_reg <= wdata[TEST_MODE_BIT]; // RQ9
                port_mirror_reg <= wdata[PORT_MIRROR_BIT]; // RQ11
            end
            if (wmask[MISC_CONFIG_FOUR_SPARE_BIT])
            begin
                misc_config_four_spare_reg <= wdata[MISC_CONFIG_FOUR_SPARE_BIT];
            end
        end
    end

    // MAC port control. Reserved bits have no storage at all.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            mac_port_enable_reg <= MAC_EN_FROM_STRAP ? strap_mac_en : MAC_EN_RST_FIXED; // RQ12
            rx_fifo_half_full_level_reg <= RX_LEVEL_RST; // RQ13
            tx_fifo_half_full_level_reg <= TX_LEVEL_RST; // RQ14
            tx_clk_shift_reg <= 1'b0; // RQ15
            rx_clk_shift_reg <= 1'b0; // RQ16
        end
        else if (wr_en && (paddr_in == ADDR_MAC_PORT_CONTROL) && wmask[0])
        begin
            mac_port_enable_reg <= wdata[MAC_EN_BIT];
            rx_fifo_half_full_level_reg <= wdata[RX_LEVEL_LSB +: 2];
            tx_fifo_half_full_level_reg <= wdata[TX_LEVEL_LSB +: 2];
            tx_clk_shift_reg <= wdata[TX_CLK_SHIFT_BIT];
            rx_clk_shift_reg <= wdata[RX_CLK_SHIFT_BIT];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            irq_mask_reg <= MASK_RST;
        end
        else if (wr_en && (paddr_in == ADDR_IRQ_MASK) && pstrb_in[0])
        begin
            irq_mask_reg <= wdata[NCAUSE-1:0];
        end
    end

    // Read mux; unused and reserved bits read zero.
    always_comb
    begin
        rdata_next = 32'h00000000;
        if (paddr_in == ADDR_LINK_DROP_CONFIG)
        begin
            rdata_next[FORCE_DROP_BIT] = force_drop_reg;
            rdata_next[FAST_DROP_ENABLE_BIT] = fast_drop_enable_reg;
            rdata_next[CAUSE_LSB +: NCAUSE] = fast_drop_cause_latched;
            rdata_next[SOURCE_MASK_LSB +: NCAUSE] = fast_drop_source_mask_reg;
        end
        else if (paddr_in == ADDR_LINK_DROP_THRESHOLD_CONFIG)
        begin
            rdata_next[THR_HI_LSB +: 3] = thr_spare_hi_reg;
            rdata_next[THR_MID_LSB +: 3] = thr_spare_mid_reg;
            rdata_next[THR_LSB +: 3] = energy_loss_threshold_reg;
        end
        else if (paddr_in == ADDR_MISC_CONFIG_FOUR)
        begin
            rdata_next[MISC_CONFIG_FOUR_SPARE_BIT] = misc_config_four_spare_reg;
            rdata_next[TEST_MODE_BIT] = internal_test_mode_one_reg;
            rdata_next[MISC_CONFIG_FOUR_FIXED_LSB +: 6] = MISC_CONFIG_FOUR_FIXED_VAL;
            rdata_next[PORT_MIRROR_BIT] = port_mirror_reg;
        end
        else if (paddr_in == ADDR_MAC_PORT_CONTROL)
        begin
            rdata_next[MAC_EN_BIT] = mac_port_enable_reg; // RQ17
            rdata_next[RX_LEVEL_LSB +: 2] = rx_fifo_half_full_level_reg;
            rdata_next[TX_LEVEL_LSB +: 2] = tx_fifo_half_full_level_reg;
            rdata_next[TX_CLK_SHIFT_BIT] = tx_clk_shift_reg;
            rdata_next[RX_CLK_SHIFT_BIT] = rx_clk_shift_reg;
        end
        else if (paddr_in == ADDR_IRQ_STATUS)
        begin
            rdata_next[NCAUSE-1:0] = irq_status;
        end
        else if (paddr_in == ADDR_IRQ_MASK)
        begin
            rdata_next[NCAUSE-1:0] = irq_mask_reg;
        end
    end

    // Capturing in the setup cycle keeps prdata a flip-flop without costing a wait state.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            prdata_reg <= 32'h00000000;
        end
        else if (psel_in && !penable_in && !pwrite_in)
        begin
            prdata_reg <= rdata_next;
        end
    end

    assign prdata_out = prdata_reg;
    assign link_drop_out = link_drop_reg;
    assign energy_lost_out = energy_lost_reg;
    assign fast_drop_enable_out = fast_drop_enable_reg;
    assign internal_test_mode_one_out = internal_test_mode_one_reg;
    assign port_mirror_out = port_mirror_reg;
    assign mac_port_enable_out = mac_port_enable_reg;
    assign rx_fifo_half_full_level_out = rx_fifo_half_full_level_reg;
    assign tx_fifo_half_full_level_out = tx_fifo_half_full_level_reg;
    assign tx_clk_shift_out = tx_clk_shift_reg;
    assign rx_clk_shift_out = rx_clk_shift_reg;
    assign irq_out = irq_reg;

endmodule

// file: tb/pld_tb_top.sv
// Self-checking bench for pld_top with a register model and drop scenarios.
// Assumes a zero-wait APB slave and straps stable from time zero.
module pld_tb_top
    import pld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, link_drop, e_lost, fde, tmo, pmo, meo, txs, rxs, irq;
    logic [1:0] rxl, txl;
    logic [3:0] st;
    logic [4:0] crit = 5'h0;
    logic sig_det = 1'b1;
    logic [7:0] acc_hi = 8'hFF;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int k;
    integer seed = 32'he9b0;
    logic [31:0] mdl [5];
    logic [ADDR_W-1:0] tbl [5] = '{ADDR_LINK_DROP_CONFIG, ADDR_LINK_DROP_THRESHOLD_CONFIG, ADDR_MISC_CONFIG_FOUR,
        ADDR_MAC_PORT_CONTROL, ADDR_IRQ_MASK};
    logic [31:0] wm [5] = '{32'hC01F, 32'h777, 32'h181, 32'hFB, 32'h1F};

    always #12.5 clk_in = ~clk_in;

    pld_top #(.MAC_EN_FROM_STRAP(1'b1)) i_pld_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .strap_fast_drop_in(st[0]),
        .strap_test_mode_in(st[1]), .strap_mirror_in(st[2]), .strap_mac_en_in(st[3]), .signal_detect_in(sig_det),
        .descrambler_sync_loss_in(crit[4]), .rx_error_in(crit[3]), .mlt3_error_in(crit[2]), .snr_low_in(crit[1]),
        .energy_acc_in(crit[0] ? 8'h00 : acc_hi), .link_drop_out(link_drop), .energy_lost_out(e_lost),
        .fast_drop_enable_out(fde), .internal_test_mode_one_out(tmo), .port_mirror_out(pmo),
        .mac_port_enable_out(meo), .rx_fifo_half_full_level_out(rxl), .tx_fifo_half_full_level_out(txl),
        .tx_clk_shift_out(txs), .rx_clk_shift_out(rxs), .irq_out(irq));

    task automatic final_report();
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // The request is held until pready is seen high; a slow answer only costs cycles.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1)
        begin
            @(posedge clk_in);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, tbl[i], d);
        mdl[i] = (mdl[i] & ~wm[i]) | (d & wm[i]);
    endtask

    task automatic rdc(input int i);
        apb(1'b0, tbl[i], 32'h0);
        chk(rd, mdl[i]);
    endtask

    task automatic outs();
        chk({fde, tmo, pmo, meo, rxl, txl, txs, rxs},
            {mdl[0][14], mdl[2][7], mdl[2][0], mdl[3][7], mdl[3][6:3], mdl[3][1:0]});
    endtask

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc >= 5000)
        begin
            num_errors++;
            final_report();
        end
    end

    initial
    begin
        st = 4'($random(seed));
        acc_hi = 8'h08 | 8'($random(seed));
        mdl[0] = 32'h0;
        mdl[1] = st[0] ? 32'h222 : 32'h221;
        mdl[2] = 32'({st[1], 6'h08, st[2]});
        mdl[3] = 32'({st[3], 7'h50});
        mdl[4] = 32'h0;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        for (k = 0; k < 5; k++)
            rdc(k);
        outs();
        for (k = 0; k < 15; k++)
        begin
            wr(k % 5, k < 5 ? 32'hFFFFFFFF : 32'($random(seed)));
            rdc(k % 5);
            outs();
        end
        wr(1, 32'h221);
        wr(2, 32'h0);
        outs();
        apb(1'b1, ADDR_MAC_PORT_CONTROL + 10'h1, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, ADDR_MAC_PORT_CONTROL + 10'h2, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        pstrb <= 4'h0;
        apb(1'b1, tbl[3], 32'h0);
        pstrb <= 4'hF;
        rdc(3);
        for (k = 0; k < 5; k++)
        begin
            wr(0, 32'h4000 | (32'h1 << k));
            wr(4, k == 2 ? 32'h0 : 32'h1 << k);
            crit <= 5'h1 << ((k + 1) % 5);
            repeat (4) @(posedge clk_in);
            chk(32'(link_drop), 32'h0);
            crit <= 5'h1 << k;
            repeat (5) @(posedge clk_in);
            chk({link_drop, irq, e_lost}, {1'b1, k != 2, k == 0});
            mdl[0][8 + k] = 1'b1;
            rdc(0);
            rdc(0);
            crit <= 5'h0;
            repeat (3) @(posedge clk_in);
            rdc(0);
            mdl[0][8 + k] = 1'b0;
            rdc(0);
            apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
            chk(rd, 32'h1 << k);
            apb(1'b1, ADDR_IRQ_STATUS, 32'h1 << k);
            apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
            chk(rd, 32'h0);
            chk({link_drop, irq}, 32'h0);
        end
        wr(0, 32'h8000);
        sig_det <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(32'(link_drop), 32'h1);
        sig_det <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk(32'(link_drop), 32'h0);
        acc_hi <= 8'h01;
        repeat (2) @(posedge clk_in);
        chk(32'(e_lost), 32'h0);
        acc_hi <= 8'h00;
        repeat (2) @(posedge clk_in);
        chk(32'(e_lost), 32'h1);
        final_report();
    end
endmodule

// file: tb/pld_top_assertions.sv
// Concurrent checks on the port behaviour of pld_top.
// Assumes only the top-level ports are visible; it is attached by bind.
module pld_top_checker
    import pld_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic signal_detect_in,
    input wire logic descrambler_sync_loss_in,
    input wire logic rx_error_in,
    input wire logic mlt3_error_in,
    input wire logic snr_low_in,
    input wire logic [ENERGY_W-1:0] energy_acc_in,
    input wire logic link_drop_out,
    input wire logic internal_test_mode_one_out,
    input wire logic port_mirror_out,
    input wire logic mac_port_enable_out,
    input wire logic [1:0] rx_fifo_half_full_level_out,
    input wire logic [1:0] tx_fifo_half_full_level_out,
    input wire logic tx_clk_shift_out,
    input wire logic rx_clk_shift_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    logic acc;
    logic wr_mac;
    logic wr_misc_config_four;
    logic crit;
    assign acc = psel_in && penable_in;
    assign wr_mac = acc && pwrite_in && pstrb_in[0] && paddr_in == ADDR_MAC_PORT_CONTROL;
    assign wr_misc_config_four = acc && pwrite_in && pstrb_in[0] && paddr_in == ADDR_MISC_CONFIG_FOUR;
    assign crit = !signal_detect_in || descrambler_sync_loss_in || rx_error_in || mlt3_error_in || snr_low_in;
    a_ready_high: assert property (pready_out)
        else $error("pready low");
    a_misaligned_err: assert property (acc && !pwrite_in && paddr_in[1:0] != 2'h0 |->
        pslverr_out && prdata_out == 32'h0)
        else $error("misaligned read not refused");
    a_mac_write: assert property (wr_mac |=> mac_port_enable_out == $past(pwdata_in[7]) &&
        tx_clk_shift_out == $past(pwdata_in[1]) && rx_clk_shift_out == $past(pwdata_in[0]))
        else $error("mac control bits not taken");
    a_level_write: assert property (wr_mac |=>
        {rx_fifo_half_full_level_out, tx_fifo_half_full_level_out} == $past(pwdata_in[6:3]))
        else $error("fifo levels not taken");
    a_mac_rsvd: assert property (acc && !pwrite_in && paddr_in == ADDR_MAC_PORT_CONTROL |->
        prdata_out[15:8] == 8'h00 && !prdata_out[2])
        else $error("reserved mac bits read nonzero");
    a_misc_config_four_write: assert property (wr_misc_config_four |=> internal_test_mode_one_out == $past(pwdata_in[7]) &&
        port_mirror_out == $past(pwdata_in[0]))
        else $error("config four bits not taken");
    a_drop_cause: assert property ($rose(link_drop_out) |->
        $past(crit) || $past(energy_acc_in < 8'h08))
        else $error("link drop without cause");
    a_reset_levels: assert property ($fell(sys_rst_in) |->
        rx_fifo_half_full_level_out == 2'h2 && tx_fifo_half_full_level_out == 2'h2 &&
        !tx_clk_shift_out && !rx_clk_shift_out)
        else $error("reset values wrong");
endmodule

bind pld_top pld_top_checker i_pld_top_checker (.*);
